// file: fwne_pkg.sv
package fwne_pkg;
  // ----------------------------------------
  // register byte offsets (word aligned)
  // ----------------------------------------
  localparam logic [7:0] FWNE_OFF_FEATURE = 8'h00;
  localparam logic [7:0] FWNE_OFF_COUNT = 8'h04;
  localparam logic [7:0] FWNE_OFF_ADDR_LOW = 8'h08;
  localparam logic [7:0] FWNE_OFF_ADDR_MID = 8'h0C;
  localparam logic [7:0] FWNE_OFF_ADDR_HIGH = 8'h10;
  localparam logic [7:0] FWNE_OFF_UNIT = 8'h14;
  localparam logic [7:0] FWNE_OFF_OPCODE = 8'h18;
  localparam logic [7:0] FWNE_OFF_FAULT = 8'h1C;
  localparam logic [7:0] FWNE_OFF_COND = 8'h20;
  localparam logic [7:0] FWNE_OFF_DATA = 8'h24;
  localparam logic [7:0] FWNE_OFF_CONFIG = 8'h28;
  localparam logic [7:0] FWNE_OFF_INFO = 8'h2C;
  // ----------------------------------------
  // opcodes
  // ----------------------------------------
  localparam logic [7:0] FWNE_OP_WR_MULTI = 8'hCD;
  localparam logic [7:0] FWNE_OP_WR_SECT = 8'h38;
  localparam logic [7:0] FWNE_OP_PWR_QUERY = 8'hE5;
  localparam logic [7:0] FWNE_OP_SET_BLOCK = 8'hC6;
  // ----------------------------------------
  // power query results
  // ----------------------------------------
  localparam logic [7:0] FWNE_PWR_STANDBY = 8'h00;
  localparam logic [7:0] FWNE_PWR_IDLE = 8'h80;
  localparam logic [7:0] FWNE_PWR_ACTIVE = 8'hFF;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int FWNE_ST_BUSY = 7;
  localparam int FWNE_ST_READY = 6;
  localparam int FWNE_ST_FAULT = 5;
  localparam int FWNE_ST_DRQ = 3;
  localparam int FWNE_ST_ERR = 0;
  localparam int FWNE_ER_NF = 4;
  localparam int FWNE_ER_ABORT = 2;
  localparam int FWNE_ER_MEDIA = 0;
  localparam int FWNE_UNIT_LBA = 6;
  localparam int FWNE_CFG_MULTI_OK = 8;
  // ----------------------------------------
  // sizes and resets
  // ----------------------------------------
  localparam logic [8:0] FWNE_FULL_COUNT = 9'h100;
  localparam logic [7:0] FWNE_WORDS_PER_SECTOR = 8'hFF;
  localparam logic [7:0] FWNE_COND_RESET = 8'h40;
  localparam logic [1:0] FWNE_RESP_OKAY = 2'h0;
  localparam logic [1:0] FWNE_RESP_SLVERR = 2'h2;
  localparam logic [27:0] FWNE_ADDR_LIMIT = 28'hFFFFFFF;
  // ----------------------------------------
  // command states
  // ----------------------------------------
  typedef enum logic [4:0] {
    FWNE_IDLE = 5'h01,
    FWNE_DATA = 5'h02,
    FWNE_PROG = 5'h04,
    FWNE_DONE = 5'h08,
    FWNE_FAIL = 5'h10
  } fwne_state_t;
endpackage : fwne_pkg

// file: fwne_core.sv
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
module fwne_core import fwne_pkg::*; #(
  parameter int ADDR_W = 8,
  parameter int BLOCK_MAX = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic media_fail, // media reports an unrecoverable write
  input wire logic unit_fault_in, // device fault event
  input wire logic [1:0] power_mode, // 0 standby, 1 idle, 2 active
  output logic [27:0] prog_addr, // sector being programmed
  output logic [15:0] prog_word, // data word toward the media
  output logic prog_word_valid, // one-cycle data strobe
  output logic prog_commit, // one-cycle program pulse, no erase
  output logic host_intr // level, set per sector or block
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    fwne_state_t st;
    logic [7:0] feature_select_reg;
    logic [7:0] transfer_count_reg;
    logic [7:0] block_addr_low_reg;
    logic [7:0] block_addr_mid_reg;
    logic [7:0] block_addr_high_reg;
    logic [7:0] unit_select_reg;
    logic [7:0] fault_cause_reg;
    logic [7:0] unit_condition_reg;
    logic [8:0] block_size_reg; // sectors per block, 0 = unset
    logic multi_ok_reg; // identify word bit: no set needed
    logic is_multi_reg;
    logic [27:0] cur_addr_reg;
    logic [8:0] left_reg; // sectors still to move
    logic [8:0] blk_left_reg; // sectors left in this block
    logic [7:0] word_cnt_reg;
    logic [15:0] word_reg;
    logic word_valid_reg;
    logic commit_reg;
    logic intr_reg;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
  } fwne_regs_t;

  fwne_regs_t q;
  fwne_regs_t d;

  // address decode shared by read and write
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a[7:0] <= FWNE_OFF_INFO) && (a[1:0] == 2'h0);
  endfunction : mapped

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  logic wr_fire;
  logic [27:0] start_addr;
  logic [8:0] count_full;
  logic [8:0] first_blk;
  always_comb begin
    d = q;
    d.word_valid_reg = 1'b0;
    d.commit_reg = 1'b0;
    // step to the next sector only after its program pulse, so the pulse still shows its own address
    if (q.commit_reg) begin
      d.cur_addr_reg = q.cur_addr_reg + 28'h1;
    end
    // start address assembled from four fields
    start_addr = {q.unit_select_reg[3:0], q.block_addr_high_reg, q.block_addr_mid_reg,
      q.block_addr_low_reg};
    // count of zero stands for a full 256
    count_full = (q.transfer_count_reg == 8'h00) ? FWNE_FULL_COUNT
      : {1'b0, q.transfer_count_reg};
    first_blk = (count_full < q.block_size_reg) ? count_full : q.block_size_reg;
    // write channel capture, either order
    if (s_axi_awvalid && !q.aw_got && !q.bvalid_reg) begin
      d.aw_got = 1'b1;
      d.awaddr_reg = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.w_got && !q.bvalid_reg) begin
      d.w_got = 1'b1;
      d.wdata_reg = s_axi_wdata;
    end
    wr_fire = q.aw_got && q.w_got;
    if (q.bvalid_reg && s_axi_bready) begin
      d.bvalid_reg = 1'b0;
    end
    if (wr_fire) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid_reg = 1'b1;
      d.bresp_reg = mapped(q.awaddr_reg) ? FWNE_RESP_OKAY : FWNE_RESP_SLVERR;
    end
    // read channel: one-cycle registered answer
    if (q.rvalid_reg && s_axi_rready) begin
      d.rvalid_reg = 1'b0;
    end
    if (s_axi_arvalid && !q.rvalid_reg) begin
      d.rvalid_reg = 1'b1;
      d.rresp_reg = mapped(s_axi_araddr) ? FWNE_RESP_OKAY : FWNE_RESP_SLVERR;
      d.rdata_reg = 32'h0000_0000;
      case (s_axi_araddr[7:0])
        FWNE_OFF_COUNT: d.rdata_reg[7:0] = q.transfer_count_reg;
        FWNE_OFF_ADDR_LOW: d.rdata_reg[7:0] = q.block_addr_low_reg;
        FWNE_OFF_ADDR_MID: d.rdata_reg[7:0] = q.block_addr_mid_reg;
        FWNE_OFF_ADDR_HIGH: d.rdata_reg[7:0] = q.block_addr_high_reg;
        FWNE_OFF_UNIT: d.rdata_reg[7:0] = q.unit_select_reg;
        FWNE_OFF_FAULT: d.rdata_reg[7:0] = q.fault_cause_reg;
        FWNE_OFF_COND: d.rdata_reg[7:0] = q.unit_condition_reg;
        FWNE_OFF_CONFIG: d.rdata_reg = {23'h0, q.multi_ok_reg, 8'h00};
        // info: erase flag and cycle counts not tracked, zero
        FWNE_OFF_INFO: d.rdata_reg = 32'h0000_0000;
        default: d.rdata_reg = 32'h0000_0000;
      endcase
      // reading the condition register clears the interrupt
      if (s_axi_araddr[7:0] == FWNE_OFF_COND) begin
        d.intr_reg = 1'b0;
      end
    end
    // register writes and command decode
    if (wr_fire && mapped(q.awaddr_reg)) begin
      case (q.awaddr_reg[7:0])
        FWNE_OFF_FEATURE: d.feature_select_reg = q.wdata_reg[7:0];
        FWNE_OFF_COUNT: d.transfer_count_reg = q.wdata_reg[7:0];
        FWNE_OFF_ADDR_LOW: d.block_addr_low_reg = q.wdata_reg[7:0];
        FWNE_OFF_ADDR_MID: d.block_addr_mid_reg = q.wdata_reg[7:0];
        FWNE_OFF_ADDR_HIGH: d.block_addr_high_reg = q.wdata_reg[7:0];
        FWNE_OFF_UNIT: d.unit_select_reg = q.wdata_reg[7:0];
        FWNE_OFF_CONFIG: d.multi_ok_reg = q.wdata_reg[FWNE_CFG_MULTI_OK];
        FWNE_OFF_DATA: begin
          // host data word while data is requested
          if (q.st == FWNE_DATA) begin
            d.word_reg = q.wdata_reg[15:0];
            d.word_valid_reg = 1'b1;
            d.word_cnt_reg = q.word_cnt_reg + 8'h01;
            if (q.word_cnt_reg == FWNE_WORDS_PER_SECTOR) begin
              d.st = FWNE_PROG;
              d.unit_condition_reg[FWNE_ST_DRQ] = 1'b0;
              d.unit_condition_reg[FWNE_ST_BUSY] = 1'b1;
            end
          end
        end
        FWNE_OFF_OPCODE: begin
          if (q.st == FWNE_IDLE) begin
            d.fault_cause_reg = 8'h00;
            d.unit_condition_reg = FWNE_COND_RESET;
            d.intr_reg = 1'b0;
            case (q.wdata_reg[7:0])
              FWNE_OP_WR_MULTI, FWNE_OP_WR_SECT: begin
                d.is_multi_reg = (q.wdata_reg[7:0] == FWNE_OP_WR_MULTI);
                d.cur_addr_reg = start_addr;
                d.left_reg = count_full;
                d.word_cnt_reg = 8'h00;
                d.blk_left_reg = (q.wdata_reg[7:0] == FWNE_OP_WR_MULTI) ? first_blk : 9'h001;
                if (q.wdata_reg[7:0] == FWNE_OP_WR_MULTI && q.block_size_reg == 9'h000
                    && !q.multi_ok_reg) begin
                  // no block size set: abort
                  d.fault_cause_reg[FWNE_ER_ABORT] = 1'b1;
                  d.st = FWNE_FAIL;
                end else if (!q.unit_select_reg[FWNE_UNIT_LBA]) begin
                  d.fault_cause_reg[FWNE_ER_ABORT] = 1'b1;
                  d.st = FWNE_FAIL;
                end else begin
                  d.st = FWNE_DATA;
                  d.unit_condition_reg[FWNE_ST_DRQ] = 1'b1;
                end
              end
              FWNE_OP_SET_BLOCK: begin
                d.block_size_reg = {1'b0, q.transfer_count_reg};
                d.st = FWNE_DONE;
              end
              FWNE_OP_PWR_QUERY: begin
                // reads the mode only, never changes it
                case (power_mode)
                  2'h0: d.transfer_count_reg = FWNE_PWR_STANDBY;
                  2'h1: d.transfer_count_reg = FWNE_PWR_IDLE;
                  default: d.transfer_count_reg = FWNE_PWR_ACTIVE;
                endcase
                d.st = FWNE_DONE;
              end
              default: begin
                d.fault_cause_reg[FWNE_ER_ABORT] = 1'b1;
                d.st = FWNE_FAIL;
              end
            endcase
          end
        end
        default: ;
      endcase
    end
    // command sequencer
    case (q.st)
      FWNE_IDLE: ;
      FWNE_DATA: ;
      FWNE_PROG: begin
        if (q.cur_addr_reg > FWNE_ADDR_LIMIT - 28'h1) begin
          d.fault_cause_reg[FWNE_ER_NF] = 1'b1;
          d.st = FWNE_FAIL;
        end else if (media_fail) begin
          d.fault_cause_reg[FWNE_ER_MEDIA] = 1'b1;
          d.st = FWNE_FAIL;
        end else begin
          d.commit_reg = 1'b1;
          d.left_reg = q.left_reg - 9'h1;
          d.blk_left_reg = q.blk_left_reg - 9'h1;
          d.word_cnt_reg = 8'h00;
          if (q.left_reg == 9'h1) begin
            d.st = FWNE_DONE;
          end else begin
            d.st = FWNE_DATA;
            d.unit_condition_reg[FWNE_ST_BUSY] = 1'b0;
            d.unit_condition_reg[FWNE_ST_DRQ] = 1'b1;
            if (q.blk_left_reg == 9'h1) begin
              d.intr_reg = 1'b1;
              d.blk_left_reg = q.is_multi_reg ? (((q.left_reg - 9'h1) < q.block_size_reg)
                ? (q.left_reg - 9'h1) : q.block_size_reg) : 9'h001;
            end
          end
        end
      end
      FWNE_DONE: begin
        d.unit_condition_reg = FWNE_COND_RESET;
        d.intr_reg = 1'b1;
        d.st = FWNE_IDLE;
      end
      FWNE_FAIL: begin
        // load failing address, finish with error
        {d.unit_select_reg[3:0], d.block_addr_high_reg, d.block_addr_mid_reg,
          d.block_addr_low_reg} = q.cur_addr_reg;
        d.unit_condition_reg = FWNE_COND_RESET;
        d.unit_condition_reg[FWNE_ST_ERR] = |q.fault_cause_reg;
        d.unit_condition_reg[FWNE_ST_FAULT] = unit_fault_in;
        d.intr_reg = 1'b1;
        d.st = FWNE_IDLE;
      end
      default: d.st = FWNE_IDLE;
    endcase
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.st <= FWNE_IDLE;
      q.unit_condition_reg <= FWNE_COND_RESET;
    end else if (clk_en) begin
      q <= d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign s_axi_awready = !q.aw_got && !q.bvalid_reg;
  assign s_axi_wready = !q.w_got && !q.bvalid_reg;
  assign s_axi_bvalid = q.bvalid_reg;
  assign s_axi_bresp = q.bresp_reg;
  assign s_axi_arready = !q.rvalid_reg;
  assign s_axi_rvalid = q.rvalid_reg;
  assign s_axi_rdata = q.rdata_reg;
  assign s_axi_rresp = q.rresp_reg;
  assign prog_addr = q.cur_addr_reg;
  assign prog_word = q.word_reg;
  assign prog_word_valid = q.word_valid_reg;
  assign prog_commit = q.commit_reg;
  assign host_intr = q.intr_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_success_status;
    @(posedge aclk) disable iff (!aresetn)
      (clk_en && q.st == FWNE_DONE) |=> (q.unit_condition_reg == FWNE_COND_RESET);
  endproperty
  a_success_status: assert property (p_success_status) else $error("bad success status");
  property p_fail_err;
    @(posedge aclk) disable iff (!aresetn)
      (clk_en && q.st == FWNE_FAIL) |=> (q.unit_condition_reg[FWNE_ST_ERR] && !q.unit_condition_reg[FWNE_ST_BUSY]
        && !q.unit_condition_reg[FWNE_ST_DRQ]);
  endproperty
  a_fail_err: assert property (p_fail_err) else $error("bad error status");
  property p_fail_fault;
    @(posedge aclk) disable iff (!aresetn)
      (clk_en && q.st == FWNE_FAIL) |=> (q.unit_condition_reg[FWNE_ST_FAULT] == $past(unit_fault_in));
  endproperty
  a_fail_fault: assert property (p_fail_fault) else $error("fault flag wrong on error end");
  property p_pwr_nondata;
    @(posedge aclk) disable iff (!aresetn)
      (clk_en && wr_fire && q.awaddr_reg[7:0] == FWNE_OFF_OPCODE && q.st == FWNE_IDLE
        && q.wdata_reg[7:0] == FWNE_OP_PWR_QUERY) |=> (q.st == FWNE_DONE && !q.unit_condition_reg[FWNE_ST_DRQ]);
  endproperty
  a_pwr_nondata: assert property (p_pwr_nondata) else $error("power query not non-data");
  property p_fail_addr;
    @(posedge aclk) disable iff (!aresetn)
      (clk_en && q.st == FWNE_FAIL) |=> (start_addr == $past(q.cur_addr_reg));
  endproperty
  a_fail_addr: assert property (p_fail_addr) else $error("failing address not loaded");
  property p_unknown_abort;
    @(posedge aclk) disable iff (!aresetn)
      (clk_en && wr_fire && q.awaddr_reg[7:0] == FWNE_OFF_OPCODE && q.st == FWNE_IDLE
        && q.wdata_reg[7:0] == 8'h00) |=> ##1 q.fault_cause_reg[FWNE_ER_ABORT];
  endproperty
  a_unknown_abort: assert property (p_unknown_abort) else $error("abort missing");
  property p_one_bit;
    @(posedge aclk) disable iff (!aresetn)
      !(q.fault_cause_reg[FWNE_ER_NF] && q.fault_cause_reg[FWNE_ER_ABORT]);
  endproperty
  a_one_bit: assert property (p_one_bit) else $error("both range bits set");
  property p_commit_prog;
    @(posedge aclk) disable iff (!aresetn)
      prog_commit |-> $past(q.st) == FWNE_PROG;
  endproperty
  a_commit_prog: assert property (p_commit_prog) else $error("commit outside program");
  property p_media;
    @(posedge aclk) disable iff (!aresetn)
      (clk_en && q.st == FWNE_PROG && media_fail && q.cur_addr_reg < FWNE_ADDR_LIMIT - 28'h1)
        |=> q.fault_cause_reg[FWNE_ER_MEDIA];
  endproperty
  a_media: assert property (p_media) else $error("media bit missing");
  property p_full_count;
    @(posedge aclk) disable iff (!aresetn)
      (clk_en && wr_fire && q.awaddr_reg[7:0] == FWNE_OFF_OPCODE && q.st == FWNE_IDLE
        && q.wdata_reg[7:0] == FWNE_OP_WR_SECT && q.transfer_count_reg == 8'h00
        && q.unit_select_reg[FWNE_UNIT_LBA]) |=> (q.left_reg == FWNE_FULL_COUNT);
  endproperty
  a_full_count: assert property (p_full_count) else $error("zero count not 256");
endmodule : fwne_core

// file: fwne_media_model.sv
`timescale 1ns/1ns
// media side: takes words and program pulses, fails one chosen sector
module fwne_media_model (
  input wire logic aclk,
  input wire logic clr,
  input wire logic [27:0] prog_addr,
  input wire logic [15:0] prog_word,
  input wire logic prog_word_valid,
  input wire logic prog_commit,
  input wire logic fail_en,
  input wire logic [27:0] fail_addr,
  output logic media_fail,
  output logic [31:0] commits_reg,
  output logic [31:0] sum_reg,
  output logic [27:0] last_reg
);
  // failure held while the bad sector is addressed
  assign media_fail = fail_en && (prog_addr == fail_addr);
  // sector programs straight onto the media, no erase step
  always @(posedge aclk) begin
    if (clr) begin
      commits_reg <= 32'h0;
      sum_reg <= 32'h0;
    end else begin
      if (prog_word_valid) sum_reg <= sum_reg + 32'(prog_word);
      if (prog_commit) commits_reg <= commits_reg + 32'h1;
      if (prog_commit) last_reg <= prog_addr;
    end
  end
endmodule : fwne_media_model

// file: tb_flash_write_no_erase_cmds.sv
`timescale 1ns/1ns
module tb_flash_write_no_erase_cmds import fwne_pkg::*;;
  logic aclk = 1'h0, aresetn = 1'h0, clk_en = 1'h1, clr = 1'h1;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata, commits, word_sum, seed = 32'h0721;
  logic awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0, bready = 1'h1, rready = 1'h1;
  logic awready, wready, bvalid, arready, rvalid, intr, intr_q = 1'h0, pwv, pcm, mfail;
  logic [1:0] bresp, rresp, power_mode = 2'h0;
  logic unit_fault_in = 1'h0, fail_en = 1'h0;
  logic [27:0] fail_addr = 28'h0, paddr, last_addr;
  logic [15:0] pword;
  int err_count = 0, compares = 0, intr_edges = 0;
  // ----------------------------------------
  // clock, design and media
  // ----------------------------------------
  always #50 aclk = ~aclk;
  fwne_core dut (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .media_fail(mfail), .unit_fault_in(unit_fault_in), .power_mode(power_mode),
    .prog_addr(paddr), .prog_word(pword), .prog_word_valid(pwv), .prog_commit(pcm),
    .host_intr(intr));
  fwne_media_model media (.aclk(aclk), .clr(clr), .prog_addr(paddr), .prog_word(pword),
    .prog_word_valid(pwv), .prog_commit(pcm), .fail_en(fail_en), .fail_addr(fail_addr),
    .media_fail(mfail), .commits_reg(commits), .sum_reg(word_sum), .last_reg(last_addr));
  // interrupt rising edges
  always @(posedge aclk) begin
    intr_q <= intr;
    if (intr && !intr_q) intr_edges <= intr_edges + 1;
  end
  // ----------------------------------------
  // helpers and expectations
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic int f_sectors(input logic [7:0] c);
    return (c == 8'h00) ? 256 : int'(c);
  endfunction : f_sectors
  function automatic logic [31:0] f_pwr(input logic [1:0] m);
    if (m == 2'h0) return 32'(FWNE_PWR_STANDBY);
    if (m == 2'h1) return 32'(FWNE_PWR_IDLE);
    return 32'(FWNE_PWR_ACTIVE);
  endfunction : f_pwr
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    chk({30'h0, got}, {30'h0, exp});
  endtask : chk_resp
  // write: address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic pa, pw, ta, tw, pb;
    pa = 1'h1;
    pw = 1'h1;
    pb = 1'h1;
    r = 2'h3;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    // waits for the answer however long; only the watchdog ends a hang
    while (pb) begin
      @(negedge aclk);
      ta = pa && awready;
      tw = pw && wready;
      pb = !bvalid;
      if (bvalid) r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic pa, ta, pr;
    pa = 1'h1;
    pr = 1'h1;
    r = 2'h3;
    d = 32'h0;
    araddr <= a;
    arvalid <= 1'h1;
    while (pr) begin
      @(negedge aclk);
      ta = pa && arready;
      pr = !rvalid;
      if (rvalid) d = rdata;
      if (rvalid) r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'h0;
      pa = pa && !ta;
    end
  endtask : axi_rd
  // register access expecting an okay answer
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk_resp(r, FWNE_RESP_OKAY);
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    logic [1:0] r;
    axi_rd(a, d, r);
    chk_resp(r, FWNE_RESP_OKAY);
  endtask : reg_rd
  // poll condition until not busy
  task automatic poll(output logic [31:0] c);
    c = 32'h80;
    while (c[FWNE_ST_BUSY] !== 1'h0) begin
      reg_rd(FWNE_OFF_COND, c);
    end
  endtask : poll
  // a missing interrupt is caught by the watchdog
  task automatic wait_intr();
    while (intr !== 1'h1) begin
      @(posedge aclk);
    end
  endtask : wait_intr
  task automatic load(input logic [7:0] cnt, input logic [27:0] a, input logic lba);
    reg_wr(FWNE_OFF_COUNT, {24'h0, cnt});
    reg_wr(FWNE_OFF_ADDR_LOW, {24'h0, a[7:0]});
    reg_wr(FWNE_OFF_ADDR_MID, {24'h0, a[15:8]});
    reg_wr(FWNE_OFF_ADDR_HIGH, {24'h0, a[23:16]});
    reg_wr(FWNE_OFF_UNIT, {24'h0, 1'h1, lba, 2'h2, a[27:24]});
  endtask : load
  // whole write command; block of bs sectors between interrupts
  task automatic run_wr(input logic [7:0] op, input logic [7:0] cnt, input logic [27:0] a,
                        input int bs, input logic ok, output logic [31:0] c);
    int total, sent, k, e0;
    logic [15:0] w;
    logic [31:0] exp_sum;
    total = f_sectors(cnt);
    sent = 0;
    e0 = intr_edges;
    exp_sum = 32'h0;
    clr <= 1'h1; // fresh media stands for pre-erased sectors
    load(cnt, a, 1'h1);
    clr <= 1'h0;
    reg_wr(FWNE_OFF_OPCODE, {24'h0, op});
    poll(c);
    while (c[FWNE_ST_DRQ] === 1'h1 && sent < total) begin
      for (k = 0; k < 256 * bs && sent * 256 + k < total * 256; k++) begin
        w = 16'(rnd());
        exp_sum = exp_sum + 32'(w);
        reg_wr(FWNE_OFF_DATA, {16'h0, w});
      end
      sent = sent + bs;
      wait_intr();
      poll(c);
    end
    if (ok) begin
      chk(c, 32'(FWNE_COND_RESET));
      chk(commits, 32'(total));
      chk(word_sum, exp_sum);
      chk({4'h0, last_addr}, {4'h0, a + 28'(total - 1)});
      chk(32'(intr_edges - e0), 32'((total + bs - 1) / bs));
    end
  endtask : run_wr
  task automatic end_of_test();
    $display("err_count %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    logic [31:0] c, v;
    logic [1:0] r;
    logic [27:0] a;
    int m;
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    reg_rd(FWNE_OFF_COND, c);
    chk(c, 32'(FWNE_COND_RESET));
    axi_rd(8'h30, v, r);
    chk_resp(r, FWNE_RESP_SLVERR);
    reg_rd(FWNE_OFF_INFO, v);
    chk(v, 32'h0);
    // power query in every mode
    for (m = 0; m < 4; m++) begin
      power_mode <= m[1:0];
      reg_wr(FWNE_OFF_OPCODE, {24'h0, FWNE_OP_PWR_QUERY});
      poll(c);
      chk(c, 32'(FWNE_COND_RESET));
      reg_rd(FWNE_OFF_COUNT, v);
      chk(v, f_pwr(m[1:0]));
    end
    a = 28'(rnd()) >> 1;
    run_wr(FWNE_OP_WR_SECT, 8'h02, a, 1, 1'h1, c);
    // lba bit clear is refused
    load(8'h01, a, 1'h0);
    reg_wr(FWNE_OFF_OPCODE, {24'h0, FWNE_OP_WR_SECT});
    poll(c);
    chk(c, 32'h41);
    reg_rd(FWNE_OFF_FAULT, v);
    chk(v, 32'h04);
    // multi write before any block size
    reg_rd(FWNE_OFF_CONFIG, v);
    if (v[FWNE_CFG_MULTI_OK] === 1'h0) begin
      load(8'h01, a, 1'h1);
      reg_wr(FWNE_OFF_OPCODE, {24'h0, FWNE_OP_WR_MULTI});
      poll(c);
      chk(c, 32'h41);
    end
    reg_wr(FWNE_OFF_COUNT, 32'h02);
    reg_wr(FWNE_OFF_OPCODE, {24'h0, FWNE_OP_SET_BLOCK});
    poll(c);
    a = 28'(rnd()) >> 1;
    run_wr(FWNE_OP_WR_MULTI, 8'h03, a, 2, 1'h1, c);
    // media failure on the second of 256 sectors, with a fault
    unit_fault_in <= 1'h1;
    fail_addr <= a + 28'h1;
    fail_en <= 1'h1;
    run_wr(FWNE_OP_WR_SECT, 8'h00, a, 1, 1'h0, c);
    chk(c, 32'h61);
    reg_rd(FWNE_OFF_FAULT, v);
    chk(v, 32'h01);
    for (m = 0; m < 4; m++) begin
      reg_rd(FWNE_OFF_ADDR_LOW + 8'(4 * m), v);
      chk(v & ((m == 3) ? 32'h0F : 32'hFF), 32'((a + 28'h1) >> (8 * m)) & 32'hFF);
    end
    unit_fault_in <= 1'h0;
    fail_en <= 1'h0;
    // start past the last user address; range is checked when the sector is programmed
    run_wr(FWNE_OP_WR_SECT, 8'h01, 28'hFFFFFFF, 1, 1'h0, c);
    chk(c, 32'h41);
    reg_rd(FWNE_OFF_FAULT, v);
    chk(v, 32'h10);
    // opcode the block does not know
    reg_wr(FWNE_OFF_OPCODE, 32'h00);
    poll(c);
    chk(c, 32'h41);
    reg_rd(FWNE_OFF_FAULT, v);
    chk(v, 32'h04);
    end_of_test();
  end
  // hang guard
  initial begin
    repeat (60000) @(posedge aclk);
    err_count++;
    end_of_test();
  end
endmodule : tb_flash_write_no_erase_cmds
